// file: verilog/cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] CMP_CTRL_ADDR = 8'h00;
	localparam logic [7:0] REF_CTRL_ADDR = 8'h04;

	// ****************************************************************
	// Comparator control fields
	// ****************************************************************
	localparam int IDLE_IRQ_STOP_BIT   = 15;
	localparam int CMP2_CHANGE_BIT     = 13;
	localparam int CMP1_CHANGE_BIT     = 12;
	localparam int CMP2_ON_BIT         = 11;
	localparam int CMP1_ON_BIT         = 10;
	localparam int CMP2_PAD_BIT        = 9;
	localparam int CMP1_PAD_BIT        = 8;
	localparam int CMP2_RESULT_BIT     = 7;
	localparam int CMP1_RESULT_BIT     = 6;
	localparam int CMP2_INVERT_BIT     = 5;
	localparam int CMP1_INVERT_BIT     = 4;
	localparam int CMP2_MINUS_BIT      = 3;
	localparam int CMP2_PLUS_BIT       = 2;
	localparam int CMP1_MINUS_BIT      = 1;
	localparam int CMP1_PLUS_BIT       = 0;

	// Writable bits; bit 14 and the result bits are not storage.
	localparam logic [15:0] CMP_CTRL_WMASK = 16'hbf3f;
	localparam logic [15:0] CMP_CTRL_RESET = 16'h0000;

	// ****************************************************************
	// Reference control fields
	// ****************************************************************
	localparam int REF_POWER_BIT  = 7;
	localparam int REF_PIN_BIT    = 6;
	localparam int REF_RANGE_BIT  = 5;
	localparam int REF_SOURCE_BIT = 4;
	localparam int REF_CODE_MSB   = 3;
	localparam int REF_CODE_LSB   = 0;
	localparam logic [7:0] REF_CTRL_RESET = 8'h00;

	// Ladder tap index out of 96 parts of source: /24 is 4 parts, /32 is 3, 1/4 is 24.
	localparam logic [6:0] TAP_STEP_WIDE   = 7'h04;
	localparam logic [6:0] TAP_STEP_FINE   = 7'h03;
	localparam logic [6:0] TAP_OFFSET_FINE = 7'h18;

endpackage

// file: verilog/dual_comparator_control.sv
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Idle stop bit blocks interrupts, comparators run
// - Output change sets per-comparator event flag
// - Enable bits switch each comparator on
// - Pad-drive bits put result on pad
// - Comparator 2 result bit, inverted when asked
// - Comparator 1 result bit, inverted when asked
// - Invert bits complement each result
// - Comparator 2 minus input: plus or minus pin
// - Comparator 2 plus input: pin or reference
// - Comparator 1 minus input: plus or minus pin
// - Comparator 1 plus input: pin or reference
// - Unimplemented bits always read zero
// - Reference enable powers ladder up or down
// - Reference pin-drive connects level to pin
// - Range bit selects /24 or offset /32 steps
// - Source bit picks external or supply pair
// - Four-bit code picks one of sixteen levels
// - Inputs from four pins plus reference
module dual_comparator_control (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        IDLE_MODE,
	input  wire logic        CMP1_RAW,
	input  wire logic        CMP2_RAW,
	output logic             CMP1_ON,
	output logic             CMP2_ON,
	output logic             CMP1_PLUS_SELECT,
	output logic             CMP1_MINUS_SELECT,
	output logic             CMP2_PLUS_SELECT,
	output logic             CMP2_MINUS_SELECT,
	output logic             CMP1_PAD,
	output logic             CMP2_PAD,
	output logic             CMP1_PAD_DRIVE,
	output logic             CMP2_PAD_DRIVE,
	output logic             REF_POWER_ON,
	output logic             REF_PIN_DRIVE,
	output logic             REF_RANGE_SELECT,
	output logic             REF_SOURCE_SELECT,
	output logic      [3:0]  REF_LEVEL_CODE,
	output logic      [6:0]  REF_LADDER_TAP,
	output logic             CMP_IRQ
);

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic [15:0] cmp_ctrl_q;
	logic [7:0]  ref_ctrl_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic [2:0]  sync1_q;
	logic [2:0]  sync2_q;
	logic [2:0]  sync3_q;
	logic [1:0]  stable_q;
	logic [1:0]  result_q;
	logic [1:0]  result_prev_q;
	logic [1:0]  change;
	logic        idle_stable_q;
	logic        take;
	logic        wr_cmp;
	logic [15:0] cmp_read;
	logic        wr_ref;
	logic [7:0]  ref_read;

	// The address phase is accepted every cycle; the slave never inserts wait states.
	assign take = HSEL && HREADY && HTRANS[1];

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= take && HWRITE;
			wr_addr_q <= HADDR[7:0];
		end
	end

	assign wr_cmp = wr_pend_q && (wr_addr_q == cmp_ctrl_pkg::CMP_CTRL_ADDR);
	assign wr_ref = wr_pend_q && (wr_addr_q == cmp_ctrl_pkg::REF_CTRL_ADDR);

	// Read image assembled from storage plus live results; bit 14 stays zero.
	// A write whose data phase ends at the edge that takes a read is forwarded,
	// so a master that pipelines a read behind a write never sees the old value.
	always_comb begin
		cmp_read = cmp_ctrl_q & cmp_ctrl_pkg::CMP_CTRL_WMASK;
		if (wr_cmp) begin
			cmp_read = HWDATA[15:0] & cmp_ctrl_pkg::CMP_CTRL_WMASK;
		end
		if (change[1]) begin
			cmp_read[cmp_ctrl_pkg::CMP2_CHANGE_BIT] = 1'b1;
		end
		if (change[0]) begin
			cmp_read[cmp_ctrl_pkg::CMP1_CHANGE_BIT] = 1'b1;
		end
		cmp_read[cmp_ctrl_pkg::CMP2_RESULT_BIT] = result_q[1];
		cmp_read[cmp_ctrl_pkg::CMP1_RESULT_BIT] = result_q[0];
	end

	// The reference image forwards a landing write in the same way.
	always_comb begin
		ref_read = ref_ctrl_q;
		if (wr_ref) begin
			ref_read = HWDATA[7:0];
		end
	end

	// Read data is registered so that it stands through the whole data phase.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			HRDATA <= 32'h0000_0000;
		end else if (take && !HWRITE) begin
			if (HADDR[7:0] == cmp_ctrl_pkg::CMP_CTRL_ADDR) begin
				HRDATA <= {16'h0000, cmp_read};
			end else if (HADDR[7:0] == cmp_ctrl_pkg::REF_CTRL_ADDR) begin
				HRDATA <= {24'h000000, ref_read};
			end else begin
				HRDATA <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			HREADYOUT <= 1'b0;
			HRESP     <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	// ****************************************************************
	// Comparator result path
	// ****************************************************************
	// Three-stage synchronisers; a value is believed once stages two and three agree.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sync1_q  <= 3'h0;
			sync2_q  <= 3'h0;
			sync3_q  <= 3'h0;
			stable_q <= 2'h0;
			idle_stable_q <= 1'b0;
		end else begin
			sync1_q <= {IDLE_MODE, CMP2_RAW, CMP1_RAW};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q[0] == sync3_q[0]) begin
				stable_q[0] <= sync3_q[0];
			end
			if (sync2_q[1] == sync3_q[1]) begin
				stable_q[1] <= sync3_q[1];
			end
			if (sync2_q[2] == sync3_q[2]) begin
				idle_stable_q <= sync3_q[2];
			end
		end
	end

	// Results are masked by enable so a disabled comparator reads a steady value.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			result_q      <= 2'h0;
			result_prev_q <= 2'h0;
		end else begin
			result_q[1] <= cmp_ctrl_q[cmp_ctrl_pkg::CMP2_ON_BIT] &
				(stable_q[1] ^ cmp_ctrl_q[cmp_ctrl_pkg::CMP2_INVERT_BIT]);
			result_q[0] <= cmp_ctrl_q[cmp_ctrl_pkg::CMP1_ON_BIT] &
				(stable_q[0] ^ cmp_ctrl_q[cmp_ctrl_pkg::CMP1_INVERT_BIT]);
			result_prev_q <= result_q;
		end
	end

	assign change = result_q ^ result_prev_q;

	// ****************************************************************
	// Control registers
	// ****************************************************************
	// Event flags: a write of zero clears, but a change in the same cycle wins.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cmp_ctrl_q <= cmp_ctrl_pkg::CMP_CTRL_RESET;
		end else begin
			if (wr_cmp) begin
				cmp_ctrl_q <= HWDATA[15:0] & cmp_ctrl_pkg::CMP_CTRL_WMASK;
			end
			if (change[1]) begin
				cmp_ctrl_q[cmp_ctrl_pkg::CMP2_CHANGE_BIT] <= 1'b1;
			end
			if (change[0]) begin
				cmp_ctrl_q[cmp_ctrl_pkg::CMP1_CHANGE_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ref_ctrl_q <= cmp_ctrl_pkg::REF_CTRL_RESET;
		end else if (wr_ref) begin
			ref_ctrl_q <= HWDATA[7:0];
		end
	end

	// ****************************************************************
	// Analog controls and interrupt
	// ****************************************************************
	// All analog steering comes from flops so the cores see glitch-free levels.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			CMP1_ON           <= 1'b0;
			CMP2_ON           <= 1'b0;
			CMP1_PLUS_SELECT  <= 1'b0;
			CMP1_MINUS_SELECT <= 1'b0;
			CMP2_PLUS_SELECT  <= 1'b0;
			CMP2_MINUS_SELECT <= 1'b0;
			CMP1_PAD_DRIVE    <= 1'b0;
			CMP2_PAD_DRIVE    <= 1'b0;
			CMP1_PAD          <= 1'b0;
			CMP2_PAD          <= 1'b0;
		end else begin
			CMP1_ON           <= cmp_ctrl_q[cmp_ctrl_pkg::CMP1_ON_BIT];
			CMP2_ON           <= cmp_ctrl_q[cmp_ctrl_pkg::CMP2_ON_BIT];
			CMP1_PLUS_SELECT  <= cmp_ctrl_q[cmp_ctrl_pkg::CMP1_PLUS_BIT];
			CMP1_MINUS_SELECT <= cmp_ctrl_q[cmp_ctrl_pkg::CMP1_MINUS_BIT];
			CMP2_PLUS_SELECT  <= cmp_ctrl_q[cmp_ctrl_pkg::CMP2_PLUS_BIT];
			CMP2_MINUS_SELECT <= cmp_ctrl_q[cmp_ctrl_pkg::CMP2_MINUS_BIT];
			CMP1_PAD_DRIVE    <= cmp_ctrl_q[cmp_ctrl_pkg::CMP1_PAD_BIT];
			CMP2_PAD_DRIVE    <= cmp_ctrl_q[cmp_ctrl_pkg::CMP2_PAD_BIT];
			CMP1_PAD <= cmp_ctrl_q[cmp_ctrl_pkg::CMP1_PAD_BIT] & result_q[0];
			CMP2_PAD <= cmp_ctrl_q[cmp_ctrl_pkg::CMP2_PAD_BIT] & result_q[1];
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			REF_POWER_ON      <= 1'b0;
			REF_PIN_DRIVE     <= 1'b0;
			REF_RANGE_SELECT  <= 1'b0;
			REF_SOURCE_SELECT <= 1'b0;
			REF_LEVEL_CODE    <= 4'h0;
			REF_LADDER_TAP    <= 7'h00;
		end else begin
			REF_POWER_ON      <= ref_ctrl_q[cmp_ctrl_pkg::REF_POWER_BIT];
			REF_PIN_DRIVE     <= ref_ctrl_q[cmp_ctrl_pkg::REF_PIN_BIT];
			REF_RANGE_SELECT  <= ref_ctrl_q[cmp_ctrl_pkg::REF_RANGE_BIT];
			REF_SOURCE_SELECT <= ref_ctrl_q[cmp_ctrl_pkg::REF_SOURCE_BIT];
			REF_LEVEL_CODE    <= ref_ctrl_q[cmp_ctrl_pkg::REF_CODE_MSB:cmp_ctrl_pkg::REF_CODE_LSB];
			// Tap in 96ths of source: wide range code*4, fine range 24+code*3.
			if (ref_ctrl_q[cmp_ctrl_pkg::REF_RANGE_BIT]) begin
				REF_LADDER_TAP <= 7'({3'h0, ref_ctrl_q[3:0]} * cmp_ctrl_pkg::TAP_STEP_WIDE);
			end else begin
				REF_LADDER_TAP <= 7'(cmp_ctrl_pkg::TAP_OFFSET_FINE +
					{3'h0, ref_ctrl_q[3:0]} * cmp_ctrl_pkg::TAP_STEP_FINE);
			end
		end
	end

	// Suppression only gates the request; flags keep setting during idle.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			CMP_IRQ <= 1'b0;
		end else begin
			CMP_IRQ <= (cmp_ctrl_q[cmp_ctrl_pkg::CMP2_CHANGE_BIT] | cmp_ctrl_q[cmp_ctrl_pkg::CMP1_CHANGE_BIT]) &
				!(cmp_ctrl_q[cmp_ctrl_pkg::IDLE_IRQ_STOP_BIT] & idle_stable_q);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// Each sequence names one step that the properties below start from.
	sequence change1_s;
		result_q[0] != result_prev_q[0];
	endsequence

	sequence change2_s;
		result_q[1] != result_prev_q[1];
	endsequence

	// A write that lands a zero on flag 1 while its comparator stays quiet.
	sequence clear1_s;
		wr_cmp && !HWDATA[cmp_ctrl_pkg::CMP1_CHANGE_BIT] && !change[0];
	endsequence

	sequence ref_write_s;
		wr_ref;
	endsequence

	// Suppression asked for by software while the synchronised idle level is high.
	sequence idle_held_s;
		cmp_ctrl_q[cmp_ctrl_pkg::IDLE_IRQ_STOP_BIT] && idle_stable_q;
	endsequence

	// Interrupt request against the flags and idle suppression.
	idle_quiet_a: assert property (@(posedge CLK) disable iff (RESET)
		idle_held_s |=> !CMP_IRQ)
		else $error("interrupt raised while idle suppressed");
	irq_flag_a: assert property (@(posedge CLK) disable iff (RESET)
		(cmp_ctrl_q[cmp_ctrl_pkg::CMP1_CHANGE_BIT] && !idle_stable_q) |=> CMP_IRQ)
		else $error("set flag did not raise interrupt");
	irq_none_a: assert property (@(posedge CLK) disable iff (RESET)
		!(cmp_ctrl_q[cmp_ctrl_pkg::CMP2_CHANGE_BIT] || cmp_ctrl_q[cmp_ctrl_pkg::CMP1_CHANGE_BIT])
		|=> !CMP_IRQ)
		else $error("interrupt raised with no flag set");

	// Event flags: set by a change, kept until software writes a zero.
	flag_set_a: assert property (@(posedge CLK) disable iff (RESET)
		change1_s |=> cmp_ctrl_q[cmp_ctrl_pkg::CMP1_CHANGE_BIT])
		else $error("comparator 1 change did not set flag");
	flag2_set_a: assert property (@(posedge CLK) disable iff (RESET)
		change2_s |=> cmp_ctrl_q[cmp_ctrl_pkg::CMP2_CHANGE_BIT])
		else $error("comparator 2 change did not set flag");
	flag_sticky_a: assert property (@(posedge CLK) disable iff (RESET)
		(cmp_ctrl_q[cmp_ctrl_pkg::CMP2_CHANGE_BIT] && !wr_cmp)
		|=> cmp_ctrl_q[cmp_ctrl_pkg::CMP2_CHANGE_BIT])
		else $error("comparator 2 flag dropped without write");
	flag1_sticky_a: assert property (@(posedge CLK) disable iff (RESET)
		(cmp_ctrl_q[cmp_ctrl_pkg::CMP1_CHANGE_BIT] && !wr_cmp)
		|=> cmp_ctrl_q[cmp_ctrl_pkg::CMP1_CHANGE_BIT])
		else $error("comparator 1 flag dropped without write");
	flag_clear_a: assert property (@(posedge CLK) disable iff (RESET)
		clear1_s |=> !cmp_ctrl_q[cmp_ctrl_pkg::CMP1_CHANGE_BIT])
		else $error("flag not cleared by a written zero");

	// Forwarded controls and results follow the register one cycle later.
	enable_out_a: assert property (@(posedge CLK) disable iff (RESET)
		1'b1 |=> CMP2_ON == $past(cmp_ctrl_q[cmp_ctrl_pkg::CMP2_ON_BIT]))
		else $error("comparator 2 enable not forwarded");
	enable1_out_a: assert property (@(posedge CLK) disable iff (RESET)
		1'b1 |=> CMP1_ON == $past(cmp_ctrl_q[cmp_ctrl_pkg::CMP1_ON_BIT]))
		else $error("comparator 1 enable not forwarded");
	disabled_quiet_a: assert property (@(posedge CLK) disable iff (RESET)
		!cmp_ctrl_q[cmp_ctrl_pkg::CMP1_ON_BIT] |=> !result_q[0])
		else $error("disabled comparator 1 shows a result");
	pad_drive_a: assert property (@(posedge CLK) disable iff (RESET)
		1'b1 |=> CMP1_PAD == ($past(cmp_ctrl_q[cmp_ctrl_pkg::CMP1_PAD_BIT]) && $past(result_q[0])))
		else $error("comparator 1 pad does not follow drive bit");
	invert_a: assert property (@(posedge CLK) disable iff (RESET)
		cmp_ctrl_q[cmp_ctrl_pkg::CMP1_ON_BIT]
		|=> result_q[0] == ($past(stable_q[0]) ^ $past(cmp_ctrl_q[cmp_ctrl_pkg::CMP1_INVERT_BIT])))
		else $error("comparator 1 result inversion wrong");
	sync_settle_a: assert property (@(posedge CLK) disable iff (RESET)
		$changed(stable_q[0]) |-> $past(sync2_q[0]) == $past(sync3_q[0]))
		else $error("comparator 1 result taken before stages agreed");

	// Read image and reference ladder.
	reserved_zero_a: assert property (@(posedge CLK) disable iff (RESET)
		!HRDATA[14] && HRDATA[31:16] == 16'h0000)
		else $error("reserved bit reads nonzero");
	tap_range_a: assert property (@(posedge CLK) disable iff (RESET)
		!ref_ctrl_q[cmp_ctrl_pkg::REF_RANGE_BIT] |=> REF_LADDER_TAP >= cmp_ctrl_pkg::TAP_OFFSET_FINE)
		else $error("fine range tap below offset");
	tap_wide_a: assert property (@(posedge CLK) disable iff (RESET)
		ref_ctrl_q[cmp_ctrl_pkg::REF_RANGE_BIT] |=> REF_LADDER_TAP[1:0] == 2'h0)
		else $error("wide range tap off its step");
	ref_load_a: assert property (@(posedge CLK) disable iff (RESET)
		ref_write_s |=> ref_ctrl_q == $past(HWDATA[7:0]))
		else $error("reference write did not land");

endmodule

`default_nettype wire

// file: dv/analog_front_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Analog comparator cores and reference ladder
// ****************************************************************
module analog_front_model (
	input  wire logic       clk,
	input  wire logic       on1,
	input  wire logic       on2,
	input  wire logic       plus1,
	input  wire logic       minus1,
	input  wire logic       plus2,
	input  wire logic       minus2,
	input  wire logic       ref_on,
	input  wire logic [6:0] tap,
	input  wire logic [6:0] pin_p1,
	input  wire logic [6:0] pin_n1,
	input  wire logic [6:0] pin_p2,
	input  wire logic [6:0] pin_n2,
	output logic            raw1,
	output logic            raw2
);
	logic       wander_q = 1'b0;
	logic [6:0] vref;
	logic [6:0] vp1;
	logic [6:0] vm1;
	logic [6:0] vp2;
	logic [6:0] vm2;

	// Levels are in 96ths of the source; a powered-down ladder gives nothing.
	assign vref = ref_on ? tap : 7'h00;
	assign vp1  = plus1 ? pin_p1 : vref;
	assign vm1  = minus1 ? pin_p1 : pin_n1;
	assign vp2  = plus2 ? pin_p2 : vref;
	assign vm2  = minus2 ? pin_p2 : pin_n2;

	// A disabled core has no defined output, so it wanders rather than sit at a level.
	always @(posedge clk) begin
		wander_q <= ~wander_q;
	end
	assign raw1 = on1 ? (vp1 > vm1) : wander_q;
	assign raw2 = on2 ? (vp2 > vm2) : wander_q;
endmodule

`default_nettype wire

// file: dv/dual_comparator_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end

// ****************************************************************
// Testbench top
// ****************************************************************
module dual_comparator_control_tb_top;
	logic        CLK = 0, RESET = 1, HSEL = 0, HWRITE = 0, IDLE_MODE = 0;
	logic [31:0] HADDR = 0, HWDATA = 0, rd, HRDATA;
	logic [1:0]  HTRANS = 0;
	logic [6:0]  p1 = 0, n1 = 0, p2 = 0, n2 = 0, tap;
	logic        HREADYOUT, HRESP, raw1, raw2, on1, on2, ps1, ms1, ps2, ms2;
	logic        pad1, pad2, pd1, pd2, rpo, rpd, rrs, rss, irq;
	logic [3:0]  code;
	int          err_count = 0, checks = 0, cyc = 0;

	dual_comparator_control dual_comparator_control_i (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.IDLE_MODE(IDLE_MODE), .CMP1_RAW(raw1), .CMP2_RAW(raw2), .CMP1_ON(on1), .CMP2_ON(on2),
		.CMP1_PLUS_SELECT(ps1), .CMP1_MINUS_SELECT(ms1), .CMP2_PLUS_SELECT(ps2),
		.CMP2_MINUS_SELECT(ms2), .CMP1_PAD(pad1), .CMP2_PAD(pad2), .CMP1_PAD_DRIVE(pd1),
		.CMP2_PAD_DRIVE(pd2), .REF_POWER_ON(rpo), .REF_PIN_DRIVE(rpd), .REF_RANGE_SELECT(rrs),
		.REF_SOURCE_SELECT(rss), .REF_LEVEL_CODE(code), .REF_LADDER_TAP(tap), .CMP_IRQ(irq));

	analog_front_model analog_front_model_i (.clk(CLK), .on1(on1), .on2(on2), .plus1(ps1),
		.minus1(ms1), .plus2(ps2), .minus2(ms2), .ref_on(rpo), .tap(tap), .pin_p1(p1),
		.pin_n1(n1), .pin_p2(p2), .pin_n2(n2), .raw1(raw1), .raw2(raw2));

	// Free-running clock and a hang guard well above the expected run length.
	always #5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			final_report();
		end
	end

	// One single word transfer; the master waits for the slave however long it takes.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		HSEL <= 1'b1;
		HADDR <= {24'h000000, a};
		HTRANS <= 2'h2;
		HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge CLK);
	endtask

	task automatic reset_values;
		bus(0, 8'h00, 0);
		`CHK("ctrl reset", 32'h00000000, rd)
		bus(0, 8'h04, 0);
		`CHK("ref reset", 32'h00000000, rd)
		bus(0, 8'h08, 0);
		`CHK("unmapped", 32'h00000000, rd)
		`CHK("resp", 1'b0, HRESP)
		`CHK("ready", 1'b1, HREADYOUT)
	endtask

	task automatic ctrl_fields;
		bus(1, 8'h00, 32'hffffc03f);
		bus(0, 8'h00, 0);
		`CHK("ctrl rw", 32'h0000803f, rd)
		settle(2);
		`CHK("selects", 4'hf, {ps1, ms1, ps2, ms2})
		`CHK("enables", 2'h0, {on1, on2})
		bus(1, 8'h00, 0);
	endtask

	// Both range settings at both ends of the code, with the source bit toggled alongside.
	task automatic ref_levels;
		logic [7:0] v;
		for (int r = 0; r < 2; r++) begin
			for (int c = 0; c < 16; c += 15) begin
				v = {2'h3, r[0], ~r[0], c[3:0]};
				bus(1, 8'h04, {24'hffffff, v});
				bus(0, 8'h04, 0);
				`CHK("ref rw", {24'h000000, v}, rd)
				settle(2);
				`CHK("tap", (r ? c[6:0] * 7'h04 : 7'h18 + c[6:0] * 7'h03), tap)
				`CHK("ref out", v, {rpo, rpd, rrs, rss, code})
			end
		end
	endtask

	// Pin levels change by non-blocking assignment so the synchroniser never races the bench.
	task automatic cmp1_flow;
		p1 <= 7'h32;
		n1 <= 7'h0a;
		bus(1, 8'h00, 32'h0501);
		settle(8);
		bus(0, 8'h00, 0);
		`CHK("c1 on", 32'h1541, rd)
		`CHK("irq set", 2'h3, {irq, pad1})
		`CHK("c1 outs", 3'h7, {pd1, on1, ps1})
		bus(1, 8'h00, 32'h0501);
		settle(8);
		bus(0, 8'h00, 0);
		`CHK("c1 clear", 32'h0541, rd)
		`CHK("irq clear", 1'b0, irq)
		bus(1, 8'h00, 32'h0511);
		settle(8);
		bus(0, 8'h00, 0);
		`CHK("c1 inv", 32'h1511, rd)
		`CHK("pad inv", 2'h2, {irq, pad1})
		bus(1, 8'h00, 32'h9511);
		IDLE_MODE <= 1'b1;
		settle(8);
		`CHK("idle irq", 1'b0, irq)
		bus(0, 8'h00, 0);
		`CHK("idle run", 32'h9511, rd)
		IDLE_MODE <= 1'b0;
		settle(8);
		`CHK("wake irq", 1'b1, irq)
		bus(1, 8'h00, 0);
	endtask

	task automatic cmp2_ref;
		n2 <= 7'h1e;
		bus(1, 8'h04, 32'h00aa);
		bus(1, 8'h00, 32'h0800);
		settle(8);
		bus(0, 8'h00, 0);
		`CHK("c2 ref", 32'h2880, rd)
		`CHK("c2 outs", 3'h4, {on2, ps2, ms2})
		bus(1, 8'h00, 32'h0800);
		n2 <= 7'h32;
		settle(8);
		bus(0, 8'h00, 0);
		`CHK("c2 drop", 32'h2800, rd)
		`CHK("c2 pad", 2'h0, {pad2, pd2})
		`CHK("c2 irq", 1'b1, irq)
	endtask

	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Reset for four cycles, then two spare edges before the first request.
	initial begin
		settle(4);
		RESET <= 1'b0;
		settle(2);
		reset_values();
		ctrl_fields();
		ref_levels();
		cmp1_flow();
		cmp2_ref();
		final_report();
	end
endmodule

`default_nettype wire
